/* i2c_host_consts.svh */
// Constants of the supply-regulator bus controller
`ifndef I2C_HOST_CONSTS_SVH
`define I2C_HOST_CONSTS_SVH

// ==========================================
// Own register map
`define REG_CTRL 4'h0
`define REG_PTR 4'h1
`define REG_COUNT 4'h2
`define REG_STAT 4'h3
`define REG_DATA0 4'h4
`define CTRL_GO 0
`define CTRL_DIR 1
`define CTRL_SEL 2
`define CTRL_KEY 3
`define CTRL_RST 8'h08
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_NACK 2
`define BUF_DEPTH 4

// ==========================================
// Device side addresses and fields
`define CHIP_ADDR_LO 7'h08
`define CHIP_ADDR_HI 7'h09
`define DEV_REG_LEVEL 8'h02
`define DEV_REG_TONE 8'h03
`define DEV_REG_LIMIT 8'h04
`define MASK_LEVEL 8'h0F
`define MASK_TONE 8'h05
`define MASK_LIMIT 8'h04

// ==========================================
// Timing
`define CLK_PERIOD_NS 40
`define SCL_QTR_NS 2500
`define SCL_QTR_CYC ((`SCL_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* i2c_host_pkg.sv */
// Types shared by the bus controller modules
package i2c_host_pkg;
    typedef enum logic [1:0] {C_START = 2'h0, C_STOP = 2'h1, C_WR = 2'h2, C_RD = 2'h3} bit_cmd_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_START = 3'h1, S_SEND = 3'h3, S_SACK = 3'h2,
        S_RECV = 3'h6, S_MACK = 3'h7, S_STOP = 3'h5
    } seq_state_t;
    typedef enum logic [1:0] {G_ADDRW = 2'h0, G_PTR = 2'h1, G_DATA = 2'h3, G_ADDRR = 2'h2} stage_t;
endpackage

/* bit_link_if.sv */
// Handshake between byte sequencer and bit engine
`timescale 1ns/1ps
interface bit_link_if;
    logic req;
    i2c_host_pkg::bit_cmd_t cmd;
    logic bit_tx;
    logic done;
    logic bit_rx;
    modport eng (input req, input cmd, input bit_tx, output done, output bit_rx);
    modport seq (output req, output cmd, output bit_tx, input done, input bit_rx);
endinterface

/* pin_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // ==========================================
    // First stage feeds only the second; idle bus reads high
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '1;
            q <= '1;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // pin_sync

/* i2c_bit_engine.sv */
// Bit-level bus engine: start, stop, bit out, bit in
`timescale 1ns/1ps
`include "i2c_host_consts.svh"
module i2c_bit_engine #(
    parameter int QTR_CYC = `SCL_QTR_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    bit_link_if.eng lnk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_q,
    output logic sda_oe_q
);
    logic [1:0] pin_s;
    logic busy_q;
    i2c_host_pkg::bit_cmd_t cmd_q;
    logic tx_q;
    logic [1:0] ph_q;
    logic [6:0] cnt_q;
    logic stretch;

    pin_sync #(.W(2)) u_sync (.clk_sys(clk_sys), .rst_b(rst_b), .d({scl_i, sda_i}), .q(pin_s));

    // ==========================================
    // Pin pattern per quarter: {clock enable, data enable}
    function automatic logic [1:0] drive(i2c_host_pkg::bit_cmd_t c, logic [1:0] p, logic b);
        logic [1:0] r;
        r = {p == 2'h0 || p == 2'h3, ~b};
        case (c)
            i2c_host_pkg::C_START: r = {p == 2'h3, p[1]};
            i2c_host_pkg::C_STOP: r = {p == 2'h0, ~p[1]};
            default: r = {p == 2'h0 || p == 2'h3, ~b};
        endcase
        return r;
    endfunction

    // Slave holding the clock low stretches the high phase
    assign stretch = (ph_q == 2'h1) && !scl_oe_q && !pin_s[1];

    // ==========================================
    // Quarter timer and phase sequencing
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_q <= 1'b0;
            cmd_q <= i2c_host_pkg::C_STOP;
            tx_q <= 1'b1;
            ph_q <= 2'h0;
            cnt_q <= 7'h00;
            lnk.done <= 1'b0;
            lnk.bit_rx <= 1'b1;
        end
        else
        begin
            lnk.done <= 1'b0;
            if (!busy_q)
            begin
                if (lnk.req)
                begin
                    busy_q <= 1'b1;
                    cmd_q <= lnk.cmd;
                    tx_q <= lnk.bit_tx;
                    ph_q <= 2'h0;
                    cnt_q <= 7'h00;
                end
            end
            else if (!stretch)
            begin
                if (cnt_q == 7'(QTR_CYC - 1))
                begin
                    cnt_q <= 7'h00;
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h2)
                        lnk.bit_rx <= pin_s[0]; // Sampled at end of clock high
                    if (ph_q == 2'h3)
                    begin
                        busy_q <= 1'b0;
                        lnk.done <= 1'b1;
                    end
                end
                else
                    cnt_q <= cnt_q + 7'h01;
            end
        end
    end

    // Pins follow the phase; they hold their level while idle
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (busy_q)
            {scl_oe_q, sda_oe_q} <= drive(cmd_q, ph_q, tx_q);
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sda_stable_a: assert property (
        (!scl_oe_q && !$past(scl_oe_q) && cmd_q inside {i2c_host_pkg::C_WR, i2c_host_pkg::C_RD})
        |-> $stable(sda_oe_q)) else $error("data moved while clock high");
    start_edge_a: assert property (
        ($rose(sda_oe_q) && !scl_oe_q) |-> cmd_q == i2c_host_pkg::C_START)
        else $error("data fell with clock high outside start");
    stop_edge_a: assert property (
        ($fell(sda_oe_q) && !scl_oe_q) |-> cmd_q == i2c_host_pkg::C_STOP)
        else $error("data rose with clock high outside stop");
    bit_time_a: assert property (
        (lnk.req && !busy_q) |-> ##[4:1000] lnk.done) else $error("bit did not finish");
endmodule // i2c_bit_engine

/* i2c_host_ctrl.sv */
// Bus master that programs the supply regulator's registers
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "i2c_host_consts.svh"
module i2c_host_ctrl #(
    parameter int QTR_CYC = `SCL_QTR_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_q,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o_q,
    output logic scl_oe_q,
    output logic sda_o_q,
    output logic sda_oe_q,
    output logic tone_key_q
);
    bit_link_if lnk ();

    i2c_host_pkg::seq_state_t st_q;
    i2c_host_pkg::stage_t stage_q;
    logic [7:0] ctrl_q;
    logic [7:0] ptr_q;
    logic [2:0] count_q;
    logic done_q;
    logic nack_q;
    logic [7:0] buf_q [`BUF_DEPTH];
    logic [7:0] shreg_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_q;
    logic restart_q;
    logic wait_q;
    logic go;
    logic last;
    logic [7:0] tgt;
    logic [7:0] rd_mux;

    i2c_bit_engine #(.QTR_CYC(QTR_CYC)) u_eng (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .lnk(lnk),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_oe_q(scl_oe_q),
        .sda_oe_q(sda_oe_q)
    );

    // ==========================================
    // Helpers
    // Chip address from the software select bit CTRL_SEL
    function automatic logic [6:0] chip_addr(logic sel);
        return sel ? `CHIP_ADDR_HI : `CHIP_ADDR_LO;
    endfunction

    // Reserved bits are forced to zero before they leave
    function automatic logic [7:0] res_mask(logic [7:0] ra, logic [7:0] d);
        logic [7:0] m;
        m = 8'hFF;
        case (ra)
            `DEV_REG_LEVEL: m = `MASK_LEVEL;
            `DEV_REG_TONE: m = `MASK_TONE;
            `DEV_REG_LIMIT: m = `MASK_LIMIT;
            default: m = 8'hFF;
        endcase
        return d & m;
    endfunction

    assign go = wr && (addr == `REG_CTRL) && wdata[`CTRL_GO] && (st_q == i2c_host_pkg::S_IDLE);
    assign last = ({1'b0, byte_q} + 3'h1) == count_q;
    assign tgt = ptr_q + {6'h00, byte_q};

    // ==========================================
    // Bit command for the current state
    always_comb
    begin
        lnk.cmd = i2c_host_pkg::C_WR;
        lnk.bit_tx = 1'b1;
        case (st_q)
            i2c_host_pkg::S_START: lnk.cmd = i2c_host_pkg::C_START;
            i2c_host_pkg::S_SEND: lnk.bit_tx = shreg_q[7];
            i2c_host_pkg::S_SACK: lnk.cmd = i2c_host_pkg::C_RD;
            i2c_host_pkg::S_RECV: lnk.cmd = i2c_host_pkg::C_RD;
            i2c_host_pkg::S_MACK: lnk.bit_tx = last;
            i2c_host_pkg::S_STOP: lnk.cmd = i2c_host_pkg::C_STOP;
            default: lnk.cmd = i2c_host_pkg::C_WR;
        endcase
    end

    // One request per bit, then wait for the engine
    assign lnk.req = (st_q != i2c_host_pkg::S_IDLE) && !wait_q;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            wait_q <= 1'b0;
        else if (lnk.done)
            wait_q <= 1'b0;
        else if (lnk.req)
            wait_q <= 1'b1;
    end

    // ==========================================
    // Byte sequencer
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= i2c_host_pkg::S_IDLE;
            stage_q <= i2c_host_pkg::G_ADDRW;
            shreg_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_q <= 2'h0;
            restart_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                i2c_host_pkg::S_IDLE:
                    if (go)
                    begin
                        st_q <= i2c_host_pkg::S_START;
                        stage_q <= i2c_host_pkg::G_ADDRW;
                        shreg_q <= {chip_addr(wdata[`CTRL_SEL]), 1'b0};
                        restart_q <= wdata[`CTRL_DIR] && (count_q != 3'h0);
                        bit_cnt_q <= 3'h0;
                        byte_q <= 2'h0;
                    end
                i2c_host_pkg::S_START:
                    if (lnk.done)
                        st_q <= i2c_host_pkg::S_SEND;
                i2c_host_pkg::S_SEND:
                    if (lnk.done)
                    begin
                        shreg_q <= {shreg_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7)
                            st_q <= i2c_host_pkg::S_SACK;
                    end
                i2c_host_pkg::S_SACK:
                    // Every ack slot is checked rather than skipped
                    if (lnk.done)
                    begin
                        if (lnk.bit_rx)
                        begin
                            st_q <= i2c_host_pkg::S_STOP;
                            restart_q <= 1'b0;
                        end
                        else
                        begin
                            case (stage_q)
                                i2c_host_pkg::G_ADDRW:
                                begin
                                    shreg_q <= ptr_q;
                                    stage_q <= i2c_host_pkg::G_PTR;
                                    st_q <= i2c_host_pkg::S_SEND;
                                end
                                i2c_host_pkg::G_PTR:
                                    if (restart_q || count_q == 3'h0)
                                        st_q <= i2c_host_pkg::S_STOP;
                                    else
                                    begin
                                        shreg_q <= res_mask(ptr_q, buf_q[0]);
                                        stage_q <= i2c_host_pkg::G_DATA;
                                        st_q <= i2c_host_pkg::S_SEND;
                                    end
                                i2c_host_pkg::G_DATA:
                                    if (last)
                                        st_q <= i2c_host_pkg::S_STOP;
                                    else
                                    begin
                                        byte_q <= byte_q + 2'h1;
                                        shreg_q <= res_mask(tgt + 8'h01, buf_q[byte_q + 2'h1]);
                                        st_q <= i2c_host_pkg::S_SEND;
                                    end
                                default:
                                    st_q <= i2c_host_pkg::S_RECV;
                            endcase
                        end
                    end
                i2c_host_pkg::S_RECV:
                    if (lnk.done)
                    begin
                        shreg_q <= {shreg_q[6:0], lnk.bit_rx};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7)
                            st_q <= i2c_host_pkg::S_MACK;
                    end
                i2c_host_pkg::S_MACK:
                    // Low ack asks for more, high ack on the last byte ends it
                    if (lnk.done)
                    begin
                        if (last)
                            st_q <= i2c_host_pkg::S_STOP;
                        else
                        begin
                            byte_q <= byte_q + 2'h1;
                            st_q <= i2c_host_pkg::S_RECV;
                        end
                    end
                i2c_host_pkg::S_STOP:
                    // A read restarts only after a full stop, never a repeated start
                    if (lnk.done)
                    begin
                        if (restart_q)
                        begin
                            restart_q <= 1'b0;
                            st_q <= i2c_host_pkg::S_START;
                            stage_q <= i2c_host_pkg::G_ADDRR;
                            shreg_q <= {chip_addr(ctrl_q[`CTRL_SEL]), 1'b1};
                            byte_q <= 2'h0;
                        end
                        else
                            st_q <= i2c_host_pkg::S_IDLE;
                    end
                default:
                    st_q <= i2c_host_pkg::S_IDLE;
            endcase
        end
    end

    // ==========================================
    // Software registers; settings are frozen while a transfer runs
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= `CTRL_RST;
            ptr_q <= 8'h00;
            count_q <= 3'h0;
        end
        else if (wr && st_q == i2c_host_pkg::S_IDLE)
        begin
            case (addr)
                `REG_CTRL: ctrl_q <= wdata & 8'h0E;
                `REG_PTR: ptr_q <= wdata;
                `REG_COUNT: count_q <= (wdata > 8'h04) ? 3'h4 : wdata[2:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Key level toward the device; resets high so bit-only tone works
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            tone_key_q <= 1'b1;
        else
            tone_key_q <= ctrl_q[`CTRL_KEY];
    end

    // Open-drain pins only ever drive low
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
        else
        begin
            scl_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
    end

    // Data buffer: loaded by software, or by the receiver
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < `BUF_DEPTH; i++)
                buf_q[i] <= 8'h00;
        end
        else if (st_q == i2c_host_pkg::S_RECV && lnk.done && bit_cnt_q == 3'h7)
            buf_q[byte_q] <= {shreg_q[6:0], lnk.bit_rx};
        else if (wr && st_q == i2c_host_pkg::S_IDLE && addr[3:2] == 2'b01)
            buf_q[addr[1:0]] <= wdata;
    end

    // Sticky status; a hardware set beats a same-cycle clear
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_q <= 1'b0;
            nack_q <= 1'b0;
        end
        else
        begin
            if (st_q == i2c_host_pkg::S_STOP && lnk.done && !restart_q)
                done_q <= 1'b1;
            else if (wr && addr == `REG_STAT && wdata[`STAT_DONE])
                done_q <= 1'b0;
            if (st_q == i2c_host_pkg::S_SACK && lnk.done && lnk.bit_rx)
                nack_q <= 1'b1;
            else if (wr && addr == `REG_STAT && wdata[`STAT_NACK])
                nack_q <= 1'b0;
        end
    end

    // ==========================================
    // Read port: data only in the cycle after the strobe
    always_comb
    begin
        rd_mux = 8'h00;
        case (addr)
            `REG_CTRL: rd_mux = ctrl_q;
            `REG_PTR: rd_mux = ptr_q;
            `REG_COUNT: rd_mux = {5'h00, count_q};
            `REG_STAT: rd_mux = {5'h00, nack_q, done_q, st_q != i2c_host_pkg::S_IDLE};
            default: rd_mux = (addr[3:2] == 2'b01) ? buf_q[addr[1:0]] : 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 8'h00;
        else
            rdata_q <= rd ? rd_mux : 8'h00;
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    byte_len_a: assert property (
        (st_q == i2c_host_pkg::S_SEND && lnk.done) |=>
        (st_q == i2c_host_pkg::S_SACK) == ($past(bit_cnt_q) == 3'h7))
        else $error("byte length is not eight bits");
    msb_first_a: assert property (
        (st_q == i2c_host_pkg::S_SEND && lnk.done) |=> shreg_q[7:1] == $past(shreg_q[6:0]))
        else $error("byte not shifted MSB first");
    nack_stop_a: assert property (
        (st_q == i2c_host_pkg::S_SACK && lnk.done && lnk.bit_rx) |=>
        st_q == i2c_host_pkg::S_STOP && nack_q && !restart_q)
        else $error("missing ack did not abort");
    stop_start_a: assert property (
        $rose(st_q == i2c_host_pkg::S_START) |->
        $past(st_q) inside {i2c_host_pkg::S_IDLE, i2c_host_pkg::S_STOP})
        else $error("start without preceding stop");
    write_addr_a: assert property (
        (st_q == i2c_host_pkg::S_START && stage_q == i2c_host_pkg::G_ADDRW) |->
        shreg_q == {chip_addr(ctrl_q[`CTRL_SEL]), 1'b0})
        else $error("write address byte wrong");
    read_restart_a: assert property (
        (st_q == i2c_host_pkg::S_STOP && lnk.done && restart_q) |=>
        st_q == i2c_host_pkg::S_START && stage_q == i2c_host_pkg::G_ADDRR && shreg_q[0])
        else $error("read transfer did not follow pointer write");
    last_ack_a: assert property (
        (st_q == i2c_host_pkg::S_MACK && lnk.req) |-> lnk.bit_tx == last)
        else $error("master ack level wrong");
    reserved_a: assert property (
        (st_q == i2c_host_pkg::S_SEND && stage_q == i2c_host_pkg::G_DATA && bit_cnt_q == 3'h0
        && tgt == `DEV_REG_LEVEL) |-> shreg_q[7:4] == 4'h0)
        else $error("reserved level bits sent nonzero");
    rdata_pulse_a: assert property (
        !rd |=> rdata_q == 8'h00) else $error("read data outside its cycle");

    write_done_c: cover property (
        st_q == i2c_host_pkg::S_STOP && lnk.done && stage_q == i2c_host_pkg::G_DATA);
    read_done_c: cover property (
        st_q == i2c_host_pkg::S_MACK && lnk.done && last);
    nack_c: cover property (
        st_q == i2c_host_pkg::S_SACK && lnk.done && lnk.bit_rx);
endmodule // i2c_host_ctrl

/* lnb_dev_model.sv */
// Behavioural regulator device on the two-wire bus
`timescale 1ns/1ps
module lnb_dev_model (
    input wire logic clk_sys,
    input wire logic por_b,
    input wire logic uv,
    input wire logic strap,
    input wire logic scl,
    input wire logic sda,
    output logic pull_q
);
    logic [7:0] regs [2:5];
    logic [7:0] sh, ptr;
    logic [3:0] n;
    logic [1:0] byt;
    logic on, rdm, ps, pd;
    // Unimplemented pointers read zero
    wire [7:0] rdv = (ptr >= 8'h02 && ptr <= 8'h05) ? regs[ptr] : 8'h00;
    // ==========================================
    // Pins sampled each clock; edges decide everything except the uv register clear
    always @(posedge clk_sys or negedge por_b)
    begin
        if (!por_b)
        begin
            for (int i = 2; i < 6; i++) regs[i] <= 8'h00;
            {on, rdm, pull_q, ps, pd} <= 5'h03;
        end
        else
        begin
            ps <= scl;
            pd <= sda;
            if (uv)
                for (int i = 2; i < 6; i++) regs[i] <= 8'h00;
            if (ps && scl && pd && !sda)
                {on, rdm, pull_q, n, byt} <= {!uv, 8'h00};
            else if (ps && scl && !pd && sda)
                {on, pull_q} <= 2'h0;
            else if (on && !ps && scl)
            begin
                n <= n + 4'h1;
                if (n < 4'h8)
                    sh <= {sh[6:0], sda};
                else if (rdm && sda)
                    on <= 1'b0;
            end
            else if (on && ps && !scl)
            begin
                // Drive only after SCL fell, so data never moves under a high clock
                if (n == 4'h8 && byt == 2'h0)
                begin
                    on <= sh[7:1] == {6'h04, strap};
                    pull_q <= sh[7:1] == {6'h04, strap};
                    rdm <= sh[0];
                    byt <= 2'h1;
                end
                else if (n == 4'h8 && !rdm)
                begin
                    if (byt != 2'h1 && ptr >= 8'h02 && ptr <= 8'h05)
                        regs[ptr] <= sh;
                    ptr <= byt == 2'h1 ? sh : ptr + 8'h01;
                    byt <= 2'h2;
                    pull_q <= 1'b1;
                end
                else if (n == 4'h9)
                begin
                    n <= 4'h0;
                    sh <= rdv;
                    ptr <= rdm ? ptr + 8'h01 : ptr;
                    pull_q <= rdm && !rdv[7];
                end
                else if (rdm)
                    pull_q <= n == 4'h8 ? 1'b0 : !sh[7];
            end
        end
    end
endmodule // lnb_dev_model

/* tb.sv */
// Self-checking bench for the regulator bus controller
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, strap = 1'b0, uv = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata_q;
    logic scl_oe_q, sda_oe_q, tone_key_q, pull_q, scl_o_q, sda_o_q;
    int fail_count = 0, checks_done = 0;
    // Open-drain wires with pull-ups
    wire scl = !scl_oe_q;
    wire sda = !(sda_oe_q || pull_q);
    // Rows: strap, pointer, count, data bytes, readback
    logic [79:0] rows [4] = '{{4'h0, 8'h02, 4'h3, 32'hFFFFFF00, 32'h0F050400},
        {4'h1, 8'h03, 4'h1, 32'h01000000, 32'h01000000},
        {4'h0, 8'h04, 4'h4, 32'h0400AA55, 32'h04000000},
        {4'h0, 8'h02, 4'h2, 32'h0A040000, 32'h0A040000}};
    i2c_host_ctrl #(.QTR_CYC(4)) i_i2c_host_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .scl_i(scl),
        .sda_i(sda), .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .sda_o_q(sda_o_q),
        .sda_oe_q(sda_oe_q),
        .tone_key_q(tone_key_q));
    lnb_dev_model i_lnb_dev_model (.clk_sys(clk_sys), .por_b(rst_b), .uv(uv),
        .strap(strap), .scl(scl), .sda(sda), .pull_q(pull_q));
    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(posedge clk_sys);
        {wr, rd} <= 2'h0;
        #1;
    endtask
    // Starts a transfer and polls done under a bound
    task automatic xfer(input logic s, input logic d, input logic [7:0] st);
        bus(1'b1, 4'h0, {5'h01, s, d, 1'b1});
        for (int t = 0; t < 3000 && rdata_q[1] !== 1'b1; t++) bus(1'b0, 4'h3, 8'h00);
        chk(rdata_q & 8'h06, st, "stat");
        bus(1'b1, 4'h3, 8'h06);
        chk({6'h00, scl, sda}, 8'h03, "idle");
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Clock, watchdog and main sequence
    initial
        forever #20 clk_sys = ~clk_sys;
    initial
    begin
        #4000000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1;
        chk({6'h00, tone_key_q, sda_oe_q | scl_oe_q}, 8'h02, "rst pins");
        rst_b <= 1'b1;
        bus(1'b0, 4'h0, 8'h00);
        chk(rdata_q, 8'h08, "ctrl rst");
        bus(1'b0, 4'hC, 8'h00);
        chk(rdata_q, 8'h00, "unmapped");
        foreach (rows[k])
        begin
            strap <= rows[k][76];
            for (int i = 0; i < 4; i++) bus(1'b1, 4'h4 + 4'(i), rows[k][63-8*i -: 8]);
            bus(1'b1, 4'h1, rows[k][75:68]);
            bus(1'b1, 4'h2, {4'h0, rows[k][67:64]});
            xfer(rows[k][76], 1'b0, 8'h02);
            xfer(rows[k][76], 1'b1, 8'h02);
            for (int i = 0; i < rows[k][67:64]; i++)
            begin
                bus(1'b0, 4'h4 + 4'(i), 8'h00);
                chk(rdata_q, rows[k][31-8*i -: 8], "readback");
            end
        end
        // Wrong strap, then lockout: both must end in a refused transfer
        strap <= 1'b1;
        xfer(1'b0, 1'b0, 8'h06);
        strap <= 1'b0;
        uv <= 1'b1;
        xfer(1'b0, 1'b0, 8'h06);
        uv <= 1'b0;
        bus(1'b1, 4'h1, 8'h02);
        bus(1'b1, 4'h2, 8'h01);
        xfer(1'b0, 1'b1, 8'h02);
        bus(1'b0, 4'h4, 8'h00);
        chk(rdata_q, 8'h00, "lockout reg");
        bus(1'b1, 4'h0, 8'h00);
        @(posedge clk_sys);
        #1;
        chk({7'h00, tone_key_q}, 8'h00, "key");
        chk({6'h00, scl_o_q, sda_o_q}, 8'h00, "pin values");
        wrap_up();
    end
endmodule // tb
